//--- design/ccrb_register_bank.sv
// ccrb_register_bank: serial-bus slave holding the charger configuration
// and status registers, with soft register reset and no-load flag.
// assumes scl/sda arrive as open-drain levels resolved by the board;
// the slave never stretches scl.
//
// How it works
// - nine byte registers 0x00..0x08; 0x05 and 0x06 read-only
// - writing one to bit 7 of 0x00 restores defaults; bit reads zero
// - bit 6 of 0x00 enables the safety timer, default on
// - bits 5:3 of 0x00 set minimum input voltage, default code 100
// - bits 2:0 of 0x00 select input current limit, default code 001
// - bits 7:3 of 0x01 set fast charge current, default 1A
// - bits 1:0 of 0x01 select pre-charge current, default code 01
// - bit 7 of 0x02 disables battery over-voltage protection, default 0
// - bits 6:4 of 0x02 select charge voltage, default code 010
// - bit 3 of 0x02 disables thermal profile derating, default 1
// - bits 2:1 of 0x02 set termination current, default 100mA
// - bits 7:4 of 0x03 set boost output current limit, default 3A
// - bits 3:1 of 0x03 set cable compensation, default code 011
// - no-load bit 0 of 0x03 follows low switch current while monitored, pulses event
`timescale 1ns/1ps
module ccrb_register_bank
  import ccrb_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_pass_monitor_active,
  input  wire logic       i_output_pass_switch_low,
  input  wire logic [7:0] i_operating_status,
  input  wire logic [7:0] i_fault_status,
  output logic            o_sda,
  output logic            o_sda_oe,
  output logic            o_noload_pulse,
  output ccrb_settings_t  o_settings
);

  //////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // writable bits of a register; zero for unmapped and read-only ones
  function automatic logic [7:0] ccrb_wr_mask(input logic [7:0] ofs);
    logic [7:0] m;
    m = MASK_NONE;
    case (ofs)
      OFS_INPUT_REG:   m = MASK_INPUT_REG;
      OFS_CHG_CURRENT: m = MASK_FULL;
      OFS_CHG_VOLTAGE: m = MASK_FULL;
      OFS_BOOST_LIMIT: m = MASK_BOOST_LIM;
      OFS_BOOST_CTRL:  m = MASK_FULL;
      OFS_NOLOAD_MISC: m = MASK_FULL;
      OFS_THERMAL:     m = MASK_FULL;
      default:         m = MASK_NONE;
    endcase
    return m;
  endfunction : ccrb_wr_mask

  // unmapped addresses read as zero
  function automatic logic [7:0] ccrb_rd_byte(
    input logic [CCRB_NUM_REGS-1:0][7:0] regs,
    input logic [7:0]                    ofs
  );
    logic [7:0] b;
    b = 8'h00;
    if (ofs < CCRB_NUM_REGS_B) begin
      b = regs[ofs[3:0]];
    end
    return b;
  endfunction : ccrb_rd_byte

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  ccrb_pins_t pins_raw;
  ccrb_pins_t pins;
  ccrb_pins_t pins_rise;
  ccrb_pins_t pins_fall;

  assign pins_raw = '{
    scl:                 i_scl,
    sda:                 i_sda,
    pass_monitor_active: i_pass_monitor_active,
    pass_switch_low:     i_output_pass_switch_low,
    operating_status:    i_operating_status,
    fault_status:        i_fault_status};

  ccrb_pin_sync u_sync (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_pins    (pins_raw),
    .o_level   (pins),
    .o_rise    (pins_rise),
    .o_fall    (pins_fall)
  );

  logic bus_start;
  logic bus_stop;

  // start and stop are sda edges while scl stays high
  assign bus_start = pins_fall.sda & pins.scl & ~pins_rise.scl;
  assign bus_stop  = pins_rise.sda & pins.scl & ~pins_rise.scl;

  //////////////////////////////////////////////////////////////////////////
  // state

  ccrb_state_t cur;
  ccrb_state_t next_cur;

  always_comb begin
    ccrb_reg03_t r3;
    logic [7:0]  rd;
    logic [7:0]  mask;
    logic        noload_now;
    ccrb_reg00_t wr0;
    r3         = ccrb_reg03_t'(cur.regs[OFS_BOOST_LIMIT[3:0]]);
    wr0        = ccrb_reg00_t'(cur.shreg);
    rd         = ccrb_rd_byte(cur.regs, cur.ptr);
    mask       = ccrb_wr_mask(cur.ptr);
    noload_now = 1'b0;
    next_cur   = cur;
    next_cur.noload_pulse = 1'b0;

    // status registers mirror the device state; reserved bit reads 0
    next_cur.regs[OFS_OP_STATUS[3:0]] =
      pins.operating_status & MASK_OP_STATUS;
    next_cur.regs[OFS_FAULT[3:0]] = pins.fault_status;

    // no-load flag only meaningful while the switch is monitored
    noload_now = pins.pass_monitor_active & pins.pass_switch_low;
    if (noload_now && !r3.no_load) begin
      next_cur.noload_pulse = 1'b1;
    end
    r3.no_load = noload_now;
    next_cur.regs[OFS_BOOST_LIMIT[3:0]] = r3;

    ////////////////////////////////////////////////////////////////////////
    // bus engine
    if (bus_start) begin
      // repeated start restarts the address phase mid-transfer
      next_cur.fsm    = ST_RECV;
      next_cur.phase  = PH_ADDR;
      next_cur.bitcnt = 4'h0;
      next_cur.sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_cur.fsm    = ST_IDLE;
      next_cur.sda_oe = 1'b0;
    end else begin
      case (cur.fsm)
        ST_IDLE: begin
          next_cur.sda_oe = 1'b0;
        end

        ST_RECV: begin
          if (pins_rise.scl) begin
            next_cur.shreg  = {cur.shreg[6:0], pins.sda};
            next_cur.bitcnt = cur.bitcnt + 4'h1;
          end else if (pins_fall.scl && cur.bitcnt == CCRB_BYTE_BITS) begin
            next_cur.fsm    = ST_ACK;
            next_cur.sda_oe = 1'b1;
            case (cur.phase)
              PH_ADDR: begin
                // a foreign address leaves the bus untouched
                if (cur.shreg[7:1] != CCRB_DEV_ADDR) begin
                  next_cur.fsm    = ST_IDLE;
                  next_cur.sda_oe = 1'b0;
                end
                next_cur.rw = cur.shreg[0];
              end
              PH_PTR: begin
                next_cur.ptr = cur.shreg;
              end
              PH_DATA: begin
                if (cur.ptr == OFS_INPUT_REG && wr0.reg_reset) begin
                  // reset wins over the rest of the byte
                  next_cur.regs = CCRB_REG_DEFAULTS;
                end else if (cur.ptr < CCRB_NUM_REGS_B) begin
                  next_cur.regs[cur.ptr[3:0]] =
                    (next_cur.regs[cur.ptr[3:0]] & ~mask) |
                    (cur.shreg & mask);
                end
                next_cur.ptr = cur.ptr + 8'h01;
              end
              default: begin
                next_cur.fsm    = ST_IDLE;
                next_cur.sda_oe = 1'b0;
              end
            endcase
          end
        end

        ST_ACK: begin
          if (pins_fall.scl) begin
            next_cur.bitcnt = 4'h0;
            if (cur.phase == PH_ADDR && cur.rw) begin
              // first read byte goes out right after the address ack
              next_cur.fsm    = ST_SEND;
              next_cur.shreg  = rd;
              next_cur.sda_oe = ~rd[7];
              next_cur.ptr    = cur.ptr + 8'h01;
            end else begin
              next_cur.fsm    = ST_RECV;
              next_cur.sda_oe = 1'b0;
              next_cur.phase  = (cur.phase == PH_ADDR) ? PH_PTR : PH_DATA;
            end
          end
        end

        ST_SEND: begin
          if (pins_fall.scl) begin
            if (cur.bitcnt == CCRB_LAST_BIT) begin
              // release for the master's acknowledge
              next_cur.fsm    = ST_MACK;
              next_cur.sda_oe = 1'b0;
            end else begin
              next_cur.shreg  = {cur.shreg[6:0], 1'b0};
              next_cur.sda_oe = ~cur.shreg[6];
              next_cur.bitcnt = cur.bitcnt + 4'h1;
            end
          end
        end

        ST_MACK: begin
          if (pins_rise.scl) begin
            next_cur.nack = pins.sda;
          end else if (pins_fall.scl) begin
            if (cur.nack) begin
              next_cur.fsm = ST_IDLE;
            end else begin
              next_cur.fsm    = ST_SEND;
              next_cur.bitcnt = 4'h0;
              next_cur.shreg  = rd;
              next_cur.sda_oe = ~rd[7];
              next_cur.ptr    = cur.ptr + 8'h01;
            end
          end
        end

        default: begin
          next_cur.fsm    = ST_IDLE;
          next_cur.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cur <= CCRB_STATE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  // open drain: only ever pull low
  assign o_sda          = 1'b0;
  assign o_sda_oe       = cur.sda_oe;
  assign o_noload_pulse = cur.noload_pulse;

  assign o_settings = '{
    input_reg:   ccrb_reg00_t'(cur.regs[OFS_INPUT_REG[3:0]]),
    chg_current: ccrb_reg01_t'(cur.regs[OFS_CHG_CURRENT[3:0]]),
    chg_voltage: ccrb_reg02_t'(cur.regs[OFS_CHG_VOLTAGE[3:0]]),
    boost_limit: ccrb_reg03_t'(cur.regs[OFS_BOOST_LIMIT[3:0]]),
    boost_ctrl:  cur.regs[OFS_BOOST_CTRL[3:0]],
    noload_misc: cur.regs[OFS_NOLOAD_MISC[3:0]],
    thermal:     cur.regs[OFS_THERMAL[3:0]]};

endmodule : ccrb_register_bank

//--- inc/ccrb_pkg.sv
// ccrb_pkg: constants, register layouts and state types of the charger
// configuration register bank.
// assumes a single 250 MHz clock; everything else is sampled into it.
package ccrb_pkg;

  //////////////////////////////////////////////////////////////////////////
  // serial bus
  localparam logic [6:0] CCRB_DEV_ADDR  = 7'h6b;
  localparam logic [3:0] CCRB_BYTE_BITS = 4'h8;
  localparam logic [3:0] CCRB_LAST_BIT  = 4'h7;

  //////////////////////////////////////////////////////////////////////////
  // register map
  localparam int         CCRB_NUM_REGS   = 9;
  localparam logic [7:0] CCRB_NUM_REGS_B = 8'h09;
  localparam logic [7:0] OFS_INPUT_REG   = 8'h00;
  localparam logic [7:0] OFS_CHG_CURRENT = 8'h01;
  localparam logic [7:0] OFS_CHG_VOLTAGE = 8'h02;
  localparam logic [7:0] OFS_BOOST_LIMIT = 8'h03;
  localparam logic [7:0] OFS_BOOST_CTRL  = 8'h04;
  localparam logic [7:0] OFS_OP_STATUS   = 8'h05;
  localparam logic [7:0] OFS_FAULT       = 8'h06;
  localparam logic [7:0] OFS_NOLOAD_MISC = 8'h07;
  localparam logic [7:0] OFS_THERMAL     = 8'h08;

  // writable bits per register, the reset bit and no-load bit excluded; MASK_OP_STATUS clears the reserved status bit as the pins are mirrored
  localparam logic [7:0] MASK_INPUT_REG  = 8'h7f;
  localparam logic [7:0] MASK_BOOST_LIM  = 8'hfe;
  localparam logic [7:0] MASK_FULL       = 8'hff;
  localparam logic [7:0] MASK_NONE       = 8'h00;
  localparam logic [7:0] MASK_OP_STATUS  = 8'hfe;

  // power-on defaults; 0x07 and 0x08 layouts are not defined here
  localparam logic [7:0] RST_INPUT_REG   = 8'h61;
  localparam logic [7:0] RST_CHG_CURRENT = 8'h2d;
  localparam logic [7:0] RST_CHG_VOLTAGE = 8'h29;
  localparam logic [7:0] RST_BOOST_LIMIT = 8'h96;
  localparam logic [7:0] RST_BOOST_CTRL  = 8'h42;
  localparam logic [7:0] RST_NOLOAD_MISC = 8'h00;
  localparam logic [7:0] RST_THERMAL     = 8'h00;
  localparam logic [7:0] RST_STATUS      = 8'h00;

  localparam logic [CCRB_NUM_REGS-1:0][7:0] CCRB_REG_DEFAULTS = {
    RST_THERMAL, RST_NOLOAD_MISC, RST_STATUS, RST_STATUS, RST_BOOST_CTRL,
    RST_BOOST_LIMIT, RST_CHG_VOLTAGE, RST_CHG_CURRENT, RST_INPUT_REG};

  //////////////////////////////////////////////////////////////////////////
  // field layouts
  typedef struct packed {
    logic       reg_reset;
    logic       safety_timer_enable;
    logic [2:0] min_input_voltage_code;
    logic [2:0] input_current_limit_code;
  } ccrb_reg00_t;

  typedef struct packed {
    logic [4:0] fast_charge_current_code;
    logic       ntc_enable;
    logic [1:0] precharge_current_code;
  } ccrb_reg01_t;

  typedef struct packed {
    logic       battery_overvoltage_disable;
    logic [2:0] charge_voltage_code;
    logic       thermal_profile_disable;
    logic [1:0] termination_current_code;
    logic       charge_enable;
  } ccrb_reg02_t;

  typedef struct packed {
    logic [3:0] boost_output_current_code;
    logic [2:0] cable_compensation_code;
    logic       no_load;
  } ccrb_reg03_t;

  typedef struct packed {
    ccrb_reg00_t input_reg;
    ccrb_reg01_t chg_current;
    ccrb_reg02_t chg_voltage;
    ccrb_reg03_t boost_limit;
    logic [7:0]  boost_ctrl;
    logic [7:0]  noload_misc;
    logic [7:0]  thermal;
  } ccrb_settings_t;

  //////////////////////////////////////////////////////////////////////////
  // pins and analog flags crossing into the clock domain
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       pass_monitor_active;
    logic       pass_switch_low;
    logic [7:0] operating_status;
    logic [7:0] fault_status;
  } ccrb_pins_t;

  localparam ccrb_pins_t CCRB_PINS_IDLE = '{
    scl: 1'b1, sda: 1'b1, pass_monitor_active: 1'b0, pass_switch_low: 1'b0,
    operating_status: 8'h00, fault_status: 8'h00};

  typedef struct packed {
    ccrb_pins_t meta;
    ccrb_pins_t sync;
    ccrb_pins_t prev;
  } ccrb_sync_state_t;

  //////////////////////////////////////////////////////////////////////////
  // bus engine state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK  = 3'b011,
    ST_SEND = 3'b010,
    ST_MACK = 3'b110
  } ccrb_fsm_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_PTR  = 2'h1,
    PH_DATA = 2'h2
  } ccrb_phase_t;

  typedef struct packed {
    ccrb_fsm_t                       fsm;
    ccrb_phase_t                     phase;
    logic                            rw;
    logic                            nack;
    logic [3:0]                      bitcnt;
    logic [7:0]                      shreg;
    logic [7:0]                      ptr;
    logic                            sda_oe;
    logic                            noload_pulse;
    logic [CCRB_NUM_REGS-1:0][7:0]   regs;
  } ccrb_state_t;

  localparam ccrb_state_t CCRB_STATE_RESET = '{
    fsm: ST_IDLE, phase: PH_ADDR, rw: 1'b0, nack: 1'b0, bitcnt: 4'h0,
    shreg: 8'h00, ptr: 8'h00, sda_oe: 1'b0, noload_pulse: 1'b0,
    regs: CCRB_REG_DEFAULTS};

endpackage : ccrb_pkg

//--- design/ccrb_pin_sync.sv
// ccrb_pin_sync: two-flop synchroniser for bus pins and analog flags,
// plus one more stage used only for edge detection.
// assumes inputs are asynchronous to i_mclk.
`timescale 1ns/1ps
module ccrb_pin_sync
  import ccrb_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire ccrb_pins_t i_pins,
  output ccrb_pins_t      o_level,
  output ccrb_pins_t      o_rise,
  output ccrb_pins_t      o_fall
);

  ccrb_sync_state_t cur;
  ccrb_sync_state_t next_cur;

  //////////////////////////////////////////////////////////////////////////
  // meta is read by sync alone; edges come from sync against prev
  always_comb begin
    next_cur      = cur;
    next_cur.meta = i_pins;
    next_cur.sync = cur.meta;
    next_cur.prev = cur.sync;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cur <= '{meta: CCRB_PINS_IDLE, sync: CCRB_PINS_IDLE,
               prev: CCRB_PINS_IDLE};
    end else begin
      cur <= next_cur;
    end
  end

  assign o_level = cur.sync;
  assign o_rise  = cur.sync & ~cur.prev;
  assign o_fall  = ~cur.sync & cur.prev;

endmodule : ccrb_pin_sync

//--- dv/ccrb_props.sv
// ccrb_props: assertions on the register bank ports.
// assumes one clock domain; bound from the testbench top.
`timescale 1ns/1ps
module ccrb_props
  import ccrb_pkg::*;
(
  input wire logic           i_mclk,
  input wire logic           i_sys_rst,
  input wire logic           i_scl,
  input wire logic           i_sda,
  input wire logic           i_pass_monitor_active,
  input wire logic           i_output_pass_switch_low,
  input wire logic [7:0]     i_operating_status,
  input wire logic [7:0]     i_fault_status,
  input wire logic           o_sda,
  input wire logic           o_sda_oe,
  input wire logic           o_noload_pulse,
  input wire ccrb_settings_t o_settings
);
  logic [54:0] cfg;
  logic        nl;
  logic        nl_cause;
  // no-load bit left out: it follows the analog flags, not the bus
  assign cfg = {o_settings[55:25], o_settings[23:0]};
  assign nl = o_settings.boost_limit.no_load;
  assign nl_cause = i_pass_monitor_active && i_output_pass_switch_low;
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  a_reset_input: assert property ($past(i_sys_rst) |->
    o_settings.input_reg == 8'h61) else $error("input byte not default");
  a_reset_charge: assert property ($past(i_sys_rst) |->
    o_settings.chg_current == 8'h2d && o_settings.chg_voltage == 8'h29)
    else $error("charge bytes not default");
  a_reset_boost: assert property ($past(i_sys_rst) |->
    o_settings.boost_limit[7:1] == 7'h4b) else $error("boost not default");
  a_reset_bit: assert property (!o_settings.input_reg.reg_reset)
    else $error("reset bit held");
  // bus writes land only while the bus clock is low
  a_settings_quiet: assert property ($changed(cfg) |->
    !$past(i_scl) && !i_scl) else $error("settings moved with scl high");
  a_oe_quiet: assert property ($changed(o_sda_oe) |->
    !$past(i_scl) && !i_scl) else $error("sda drive moved with scl high");
  a_noload_event: assert property ($rose(nl) |-> ##[0:1] o_noload_pulse)
    else $error("no pulse on no-load");
  a_pulse_single: assert property (o_noload_pulse |=> !o_noload_pulse)
    else $error("pulse too long");
  a_noload_set: assert property (nl_cause [*6] |-> nl)
    else $error("no-load bit not set");
  a_noload_clear: assert property ((!nl_cause) [*6] |-> !nl)
    else $error("no-load bit not cleared");

  c_ack: cover property ($rose(o_sda_oe));
  c_pulse: cover property (o_noload_pulse);
  c_write: cover property ($changed(cfg));
endmodule : ccrb_props

//--- dv/ccrb_host.sv
// ccrb_host: serial bus master model standing in for the host.
// assumes an open-drain data line resolved by the testbench.
`timescale 1ns/1ps
module ccrb_host
  import ccrb_pkg::*;
(
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  localparam realtime QTR = 31.25;  // quarter of a 125 ns bus clock
  initial begin
    o_scl = 1'b1;  // bus clock stands high between frames
    o_sda_low = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic start_cond();  // also a repeated start
    o_sda_low = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b1;
    #QTR o_scl = 1'b0;
    #QTR;
  endtask : start_cond

  task automatic stop_cond();
    o_sda_low = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b0;
    #QTR;
  endtask : stop_cond

  // nine clocks: eight bits msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic ninth,
                         output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    logic [8:0] rv;
    sh = {tx, ninth};
    for (int i = 8; i >= 0; i--) begin
      o_sda_low = !sh[i];
      #QTR o_scl = 1'b1;
      #QTR rv[i] = i_sda;
      #QTR o_scl = 1'b0;
      #QTR;
    end
    rx = rv[8:1];
    ack = !rv[0];
  endtask : byte_io

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] ofs,
                           input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    a1 = 1'b0;
    a2 = 1'b0;
    start_cond();
    byte_io({addr, 1'b0}, 1'b1, rx, a0);
    if (a0) begin
      byte_io(ofs, 1'b1, rx, a1);
      byte_io(data, 1'b1, rx, a2);
    end
    stop_cond();
    ok = a0 && a1 && a2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data,
                          output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start_cond();
    byte_io({CCRB_DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_io(ofs, 1'b1, rx, a1);
    start_cond();
    byte_io({CCRB_DEV_ADDR, 1'b1}, 1'b1, rx, a2);
    byte_io(8'hff, 1'b1, data, a3);  // master nack ends the read
    stop_cond();
    ok = a0 && a1 && a2 && !a3;  // slave must let go for the master nack
  endtask : read_reg

  // two bytes written, then both read back: the pointer steps per byte
  task automatic burst(input logic [7:0] ofs, input logic [15:0] wdata,
                       output logic [15:0] rdata, output logic ok);
    logic [7:0] rx;
    logic [7:0] a;
    logic       nk;
    start_cond();
    byte_io({CCRB_DEV_ADDR, 1'b0}, 1'b1, rx, a[0]);
    byte_io(ofs, 1'b1, rx, a[1]);
    byte_io(wdata[15:8], 1'b1, rx, a[2]);
    byte_io(wdata[7:0], 1'b1, rx, a[3]);
    start_cond();
    byte_io({CCRB_DEV_ADDR, 1'b0}, 1'b1, rx, a[4]);
    byte_io(ofs, 1'b1, rx, a[5]);
    start_cond();
    byte_io({CCRB_DEV_ADDR, 1'b1}, 1'b1, rx, a[6]);
    byte_io(8'hff, 1'b0, rdata[15:8], a[7]);  // master ack asks for more
    byte_io(8'hff, 1'b1, rdata[7:0], nk);
    stop_cond();
    ok = (a == 8'hff) && !nk;
  endtask : burst
endmodule : ccrb_host

//--- dv/testbench.sv
// testbench: self-checking bench of the register bank and host model.
// assumes the package, host model and checker compile first.
`timescale 1ns/1ps
module testbench
  import ccrb_pkg::*;
;
  localparam int LIMIT = 90000;  // roughly 1.8 times the expected run
  logic           mclk;
  logic           sys_rst;
  logic           scl;
  logic           host_sda_low;
  logic           sda_line;
  logic           pass_active;
  logic           switch_low;
  logic [7:0]     op_status;
  logic [7:0]     flt_status;
  logic           sda_out;
  logic           sda_oe;
  logic           noload_pulse;
  ccrb_settings_t settings;
  int             comparisons;
  int             miscompares;
  int             cycles;

  assign sda_line = !(host_sda_low || (sda_oe && !sda_out));  // pull-up

  ccrb_register_bank dut_u (
    .i_mclk(mclk), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda_line),
    .i_pass_monitor_active(pass_active),
    .i_output_pass_switch_low(switch_low),
    .i_operating_status(op_status), .i_fault_status(flt_status),
    .o_sda(sda_out), .o_sda_oe(sda_oe), .o_noload_pulse(noload_pulse),
    .o_settings(settings));
  ccrb_host host_u (.i_sda(sda_line), .o_scl(scl), .o_sda_low(host_sda_low));

  always #2 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic set_pins(input logic [7:0] op, input logic [7:0] flt,
                          input logic act, input logic low);
    @(posedge mclk);
    #1;
    op_status = op;
    flt_status = flt;
    pass_active = act;
    switch_low = low;
  endtask : set_pins

  task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
    logic ok;
    host_u.write_reg(CCRB_DEV_ADDR, ofs, data, ok);
    check(8'(ok), 8'h01);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host_u.read_reg(ofs, d, ok);
    check(8'(ok), 8'h01);
    check(d, exp);
  endtask : rd_chk
  //////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    logic [7:0] dflt [9];
    dflt = '{8'h61, 8'h2d, 8'h29, 8'h96, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00};
    check(settings.input_reg, 8'h61);
    check(settings.chg_current, 8'h2d);
    check(settings.chg_voltage, 8'h29);
    check({settings.boost_limit[7:1], 1'b0}, 8'h96);
    for (int i = 0; i < 9; i++) rd_chk(8'(i), dflt[i]);
  endtask : t_defaults

  // every field moved off its default; read-only places written too
  task automatic t_readwrite();
    logic [7:0]  wv [9];
    logic [7:0]  rv [9];
    logic [7:0]  ev [7];
    logic [55:0] sv;
    wv = '{8'h3a, 8'hd2, 8'hc6, 8'h69, 8'ha5, 8'hff, 8'h00, 8'h5a, 8'h3c};
    rv = '{8'h3a, 8'hd2, 8'hc6, 8'h68, 8'ha5, 8'h36, 8'h9c, 8'h5a, 8'h3c};
    ev = '{8'h3c, 8'h5a, 8'ha5, 8'h68, 8'hc6, 8'hd2, 8'h3a};
    set_pins(8'h37, 8'h9c, 1'b0, 1'b0);
    for (int i = 0; i < 9; i++) wr(8'(i), wv[i]);
    sv = settings;
    for (int i = 0; i < 7; i++) check(sv[8*i +: 8], ev[i]);
    for (int i = 0; i < 9; i++) rd_chk(8'(i), rv[i]);
    wr(8'h09, 8'h77);
    rd_chk(8'h09, 8'h00);
  endtask : t_readwrite

  // multi-byte write and multi-byte read with master acknowledge
  task automatic t_burst();
    logic [15:0] d;
    logic        ok;
    host_u.burst(OFS_NOLOAD_MISC, 16'hc381, d, ok);
    check(8'(ok), 8'h01);
    check(d[15:8], 8'hc3);
    check(d[7:0], 8'h81);
    check(settings.noload_misc, 8'hc3);
    check(settings.thermal, 8'h81);
  endtask : t_burst

  task automatic t_soft_reset();
    set_pins(8'h00, 8'h00, 1'b0, 1'b0);
    wr(8'h00, 8'h80);
    t_defaults();
  endtask : t_soft_reset

  task automatic t_bad_addr();
    logic ok;
    host_u.write_reg(7'h6a, 8'h01, 8'h00, ok);
    check(8'(ok), 8'h00);
    rd_chk(8'h01, 8'h2d);
  endtask : t_bad_addr

  task automatic t_noload();
    logic seen;
    seen = 1'b0;
    set_pins(8'h00, 8'h00, 1'b1, 1'b1);
    repeat (20) begin
      @(negedge mclk);
      seen = seen || (noload_pulse === 1'b1);
    end
    check(8'(seen), 8'h01);
    rd_chk(8'h03, 8'h97);
    set_pins(8'h00, 8'h00, 1'b0, 1'b1);  // low current but not monitored
    rd_chk(8'h03, 8'h96);
  endtask : t_noload
  //////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    pass_active = 1'b0;
    switch_low = 1'b0;
    op_status = 8'h00;
    flt_status = 8'h00;
    comparisons = 0;
    miscompares = 0;
    repeat (10) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge mclk);
    t_defaults();
    t_readwrite();
    t_burst();
    t_soft_reset();
    t_bad_addr();
    t_noload();
    final_report();
  end

  initial cycles = 0;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      final_report();
    end
  end
endmodule : testbench

bind ccrb_register_bank ccrb_props chk_u (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda),
  .i_pass_monitor_active(i_pass_monitor_active),
  .i_output_pass_switch_low(i_output_pass_switch_low),
  .i_operating_status(i_operating_status),
  .i_fault_status(i_fault_status), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .o_noload_pulse(o_noload_pulse), .o_settings(o_settings));
